// ==== src/ser_pkg.sv ====
/*
 * Package for the status and event reporting block: register map,
 * status byte and event register bit positions, event codes, types.
 * Assumes a 32-bit classic Wishbone register bus with byte offsets.
 */
`default_nettype none
package ser_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_ESR      = 8'h00; // event status, write one to clear
	localparam logic [7:0] ADDR_ESE      = 8'h04; // event status enable
	localparam logic [7:0] ADDR_STB      = 8'h08; // status byte, read only
	localparam logic [7:0] ADDR_SRE      = 8'h0C; // service request enable
	localparam logic [7:0] ADDR_EVQ_POP  = 8'h10; // oldest queued code, read removes it
	localparam logic [7:0] ADDR_EVQ_CNT  = 8'h14; // queued entry count
	localparam logic [7:0] ADDR_OUTQ     = 8'h18; // output queue word, read empties it
	localparam logic [7:0] ADDR_INT_STAT = 8'h1C; // sticky interrupt events, write one to clear
	localparam logic [7:0] ADDR_INT_MASK = 8'h20; // interrupt enable mask

	// event status register bits
	localparam int ESR_OPC      = 0;
	localparam int ESR_QUERY    = 2;
	localparam int ESR_DEVICE   = 3;
	localparam int ESR_EXEC     = 4;
	localparam int ESR_CMD      = 5;
	localparam int ESR_POWER_ON = 7;

	// status byte bits
	localparam int STB_QNE = 2;
	localparam int STB_MAV = 4;
	localparam int STB_ESB = 5;
	localparam int STB_MSS = 6;

	// interrupt status bits
	localparam int INT_QUEUED  = 0;
	localparam int INT_OVERFLW = 1;
	localparam int INT_MSG     = 2;
	localparam int INT_SRQ     = 3;
	localparam int INT_W       = 4;

	// event codes
	localparam logic signed [15:0] CODE_CMD_LO   = 16'sd100;
	localparam logic signed [15:0] CODE_CMD_HI   = 16'sd168;
	localparam logic signed [15:0] CODE_EXEC_LO  = 16'sd200;
	localparam logic signed [15:0] CODE_EXEC_HI  = 16'sd258;
	localparam logic signed [15:0] CODE_DEV_A    = 16'sd300;
	localparam logic signed [15:0] CODE_DEV_B    = 16'sd310;
	localparam logic signed [15:0] CODE_DEV_C    = 16'sd361;
	localparam logic signed [15:0] CODE_PWR_ON   = 16'sd401;
	localparam logic signed [15:0] CODE_OPC      = 16'sd402;
	localparam logic signed [15:0] CODE_WARN     = 16'sd500;
	localparam logic signed [15:0] CODE_OVERFLOW = -16'sd350;
	localparam logic signed [15:0] CODE_QUERY    = -16'sd410;

	// reset values, the default queue depth and the completion answer
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [31:0] OPC_REPLY = 32'h0000_0001;
	localparam int          EVQ_DEPTH_DEF = 8;

	typedef struct packed {
		logic              valid;
		logic signed [15:0] code;
	} ser_event_s;

	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} ser_resp_s;

	typedef enum logic {OPC_IDLE, OPC_WAIT} ser_opc_e;
endpackage
`default_nettype wire

// ==== src/ser_status_event.sv ====
/*
 * Status and event reporting: event status register, event queue,
 * output queue word, status byte with summary bits, completion query,
 * interrupt status/mask, classic Wishbone slave.
 * Assumes event, response and command strobes come from logic on clk.
 */
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ser_status_event #(
	parameter int EVQ_DEPTH = ser_pkg::EVQ_DEPTH_DEF
) (
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire logic              ce,
	// wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	// device side
	input  wire ser_pkg::ser_event_s evIn,
	input  wire ser_pkg::ser_resp_s  respIn,
	input  wire logic              newMsg,
	input  wire logic              opcQuery,
	input  wire logic              opBusy,
	output logic                   srq,
	output logic                   irq
);
	localparam int PW = $clog2(EVQ_DEPTH);

	// fewer than two slots leaves no room for the overflow marker
	if (EVQ_DEPTH < 2) begin : gDepthLow
		$error("EVQ_DEPTH must be at least 2");
	end
	// the pointers wrap by overflow, so only powers of two are served
	if ((EVQ_DEPTH & (EVQ_DEPTH - 1)) != 0) begin : gDepthPow
		$error("EVQ_DEPTH must be a power of two");
	end

	// maps an event code to its event status register bits
	// codes outside every listed range still queue but set no bit
	function automatic logic [7:0] classify(input logic signed [15:0] c);
		logic [7:0] m;
		m = 8'h00;
		if (c >= ser_pkg::CODE_CMD_LO && c <= ser_pkg::CODE_CMD_HI)
			m[ser_pkg::ESR_CMD] = 1'b1;
		if (c >= ser_pkg::CODE_EXEC_LO && c <= ser_pkg::CODE_EXEC_HI)
			m[ser_pkg::ESR_EXEC] = 1'b1;
		if (c == ser_pkg::CODE_DEV_A || c == ser_pkg::CODE_DEV_B || c == ser_pkg::CODE_DEV_C
			|| c == ser_pkg::CODE_OVERFLOW)
			m[ser_pkg::ESR_DEVICE] = 1'b1;
		if (c == ser_pkg::CODE_WARN)
			m[ser_pkg::ESR_DEVICE] = 1'b1;
		if (c == ser_pkg::CODE_PWR_ON)
			m[ser_pkg::ESR_POWER_ON] = 1'b1;
		if (c == ser_pkg::CODE_OPC)
			m[ser_pkg::ESR_OPC] = 1'b1;
		if (c == ser_pkg::CODE_QUERY)
			m[ser_pkg::ESR_QUERY] = 1'b1;
		return m;
	endfunction

	// stored state
	logic [7:0]              esr;
	logic [7:0]              ese;
	logic [7:0]              sre;
	logic [ser_pkg::INT_W-1:0] intStat;
	logic [ser_pkg::INT_W-1:0] intMask;
	logic signed [15:0]      evq [EVQ_DEPTH];
	logic [PW-1:0]           rdPtr;
	logic [PW-1:0]           wrPtr;
	logic [PW:0]             evCount;
	logic [31:0]             outWord;
	logic                    mav;
	logic                    queryErrPend;
	logic                    mssPrev;
	ser_pkg::ser_opc_e       opcState;

	// combinational helpers
	logic                    busReq;
	logic                    busWr;
	logic                    busRd;
	logic [31:0]             wrMask;
	logic                    qPush;
	logic signed [15:0]      qCode;
	logic                    qPop;
	logic                    qFull;
	logic                    qOverflow;
	logic                    outPut;
	logic [31:0]             outVal;
	logic                    outLost;
	logic [7:0]              stbLow;
	logic                    esb;
	logic                    mss;
	logic [7:0]              stbByte;
	logic [ser_pkg::INT_W-1:0] intEvt;

	// request is taken on the edge that raises ack
	// ack in the taking term keeps a held request from being taken twice
	assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign busWr  = busReq && wb_we_i;
	assign busRd  = busReq && !wb_we_i;
	assign wrMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}
		& wb_dat_i;

	// queue input: external event first, a pending query error takes a free cycle
	// a same-cycle pop frees a slot, so that push is no overflow
	assign qPush = evIn.valid || queryErrPend;
	assign qCode = evIn.valid ? evIn.code : ser_pkg::CODE_QUERY;
	assign qPop  = busRd && wb_adr_i == ser_pkg::ADDR_EVQ_POP && evCount != '0;
	assign qFull = evCount == (PW+1)'(EVQ_DEPTH);
	assign qOverflow = qPush && qFull && !qPop;

	// output queue: completion answer or parser response
	// a parser response goes first; the completion answer waits a cycle
	assign outPut = respIn.valid || (opcState == ser_pkg::OPC_WAIT && !opBusy);
	assign outVal = respIn.valid ? respIn.data : ser_pkg::OPC_REPLY;
	assign outLost = newMsg && mav;

	// status byte; summary bit built from the other bits only
	// srq follows the summary bit combinationally, with no added latency
	assign esb = |(esr & ese);
	always_comb begin
		stbLow = 8'h00;
		stbLow[ser_pkg::STB_QNE] = evCount != '0;
		stbLow[ser_pkg::STB_MAV] = mav;
		stbLow[ser_pkg::STB_ESB] = esb;
	end
	assign mss = |(stbLow & sre & ~(8'h01 << ser_pkg::STB_MSS));
	assign stbByte = stbLow | ({7'h00, mss} << ser_pkg::STB_MSS);
	assign srq = mss;

	// standard event status: set wins over the write-one clear
	// a clear and an event in one cycle leave the bit set, so none is lost
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			esr <= ser_pkg::RST_BYTE;
		end else if (ce) begin
			esr <= (esr & ~((busWr && wb_adr_i == ser_pkg::ADDR_ESR) ? wrMask[7:0] : 8'h00))
				| (evIn.valid ? classify(evIn.code) : 8'h00)
				| (outLost ? classify(ser_pkg::CODE_QUERY) : 8'h00)
				| (qOverflow ? classify(ser_pkg::CODE_OVERFLOW) : 8'h00);
		end
	end

	// enable registers written by software
	// byte-wide registers, so only the lowest lane carries them
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ese     <= ser_pkg::RST_BYTE;
			sre     <= ser_pkg::RST_BYTE;
			intMask <= '0;
		end else if (ce && busWr && wb_sel_i[0]) begin
			case (wb_adr_i)
				ser_pkg::ADDR_ESE:      ese <= wb_dat_i[7:0];
				ser_pkg::ADDR_SRE:      sre <= wb_dat_i[7:0];
				ser_pkg::ADDR_INT_MASK: intMask <= wb_dat_i[ser_pkg::INT_W-1:0];
				default: ;
			endcase
		end
	end

	// event queue storage; a push into a full queue rewrites the newest slot
	// no reset on the storage: a slot is only read while the count covers it
	always_ff @(posedge clk) begin
		if (ce && qPush) begin
			if (qOverflow)
				evq[wrPtr - PW'(1)] <= ser_pkg::CODE_OVERFLOW;
			else
				evq[wrPtr] <= qCode;
		end
	end

	// queue pointers and count, first in first out
	// count is one bit wider than the pointers so full and empty differ
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdPtr   <= '0;
			wrPtr   <= '0;
			evCount <= '0;
		end else if (ce) begin
			if (qPush && !qOverflow)
				wrPtr <= wrPtr + PW'(1);
			if (qPop)
				rdPtr <= rdPtr + PW'(1);
			if (qPush && !qOverflow && !qPop)
				evCount <= evCount + (PW+1)'(1);
			else if (qPop && !(qPush && !qOverflow))
				evCount <= evCount - (PW+1)'(1);
		end
	end

	// query error waits for a cycle with no external event
	// it never displaces an external event; it is only delayed
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			queryErrPend <= 1'b0;
		else if (ce)
			queryErrPend <= outLost || (queryErrPend && evIn.valid);
	end

	// output queue word; a new message drops any unread answer
	// placing an answer wins over the clear, so no answer is lost to a strobe
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			outWord <= '0;
			mav     <= 1'b0;
		end else if (ce) begin
			if (outPut) begin
				outWord <= outVal;
				mav     <= 1'b1;
			end else if (newMsg || (busRd && wb_adr_i == ser_pkg::ADDR_OUTQ)) begin
				mav <= 1'b0;
			end
		end
	end

	// completion query: the answer waits for every pending operation
	// a response in the same cycle keeps the state, so the 1 follows it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			opcState <= ser_pkg::OPC_IDLE;
		end else if (ce) begin
			case (opcState)
				ser_pkg::OPC_IDLE:
					if (opcQuery)
						opcState <= ser_pkg::OPC_WAIT;
				ser_pkg::OPC_WAIT:
					if (!opBusy && !respIn.valid)
						opcState <= ser_pkg::OPC_IDLE;
				default: opcState <= ser_pkg::OPC_IDLE;
			endcase
		end
	end

	// interrupt events, sticky; set wins over clear
	// summary interrupt fires on the rise only, not while the bit stands
	always_comb begin
		intEvt = '0;
		intEvt[ser_pkg::INT_QUEUED]  = qPush;
		intEvt[ser_pkg::INT_OVERFLW] = qOverflow;
		intEvt[ser_pkg::INT_MSG]     = outPut;
		intEvt[ser_pkg::INT_SRQ]     = mss && !mssPrev;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			intStat <= '0;
			mssPrev <= 1'b0;
		end else if (ce) begin
			mssPrev <= mss;
			intStat <= (intStat & ~((busWr && wb_adr_i == ser_pkg::ADDR_INT_STAT)
				? wrMask[ser_pkg::INT_W-1:0] : '0)) | intEvt;
		end
	end

	// level output built from flip-flops only, so inputs cannot glitch it
	assign irq = |(intStat & intMask);

	// bus answer one cycle after the request, data from flip-flops
	// read data moves only on a taken read, so it holds until the next one
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else if (ce) begin
			wb_ack_o <= busReq;
			if (busRd) begin
				case (wb_adr_i)
					ser_pkg::ADDR_ESR:      wb_dat_o <= {24'h0, esr};
					ser_pkg::ADDR_ESE:      wb_dat_o <= {24'h0, ese};
					ser_pkg::ADDR_STB:      wb_dat_o <= {24'h0, stbByte};
					ser_pkg::ADDR_SRE:      wb_dat_o <= {24'h0, sre};
					ser_pkg::ADDR_EVQ_POP:  wb_dat_o <= (evCount != '0)
						? {{16{evq[rdPtr][15]}}, evq[rdPtr]} : 32'h0000_0000;
					ser_pkg::ADDR_EVQ_CNT:  wb_dat_o <= 32'(evCount);
					ser_pkg::ADDR_OUTQ:     wb_dat_o <= mav ? outWord : 32'h0000_0000;
					ser_pkg::ADDR_INT_STAT: wb_dat_o <= 32'(intStat);
					ser_pkg::ADDR_INT_MASK: wb_dat_o <= 32'(intMask);
					default:                wb_dat_o <= 32'h0000_0000; // unmapped reads zero
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ==== verification/ser_host_model.sv ====
/*
 * Host model: classic Wishbone master doing single register accesses.
 * Assumes one clock shared with the slave; the bench watchdog ends hangs.
 */
`timescale 1ns/1ps
`default_nettype none
module ser_host_model (
	input  wire logic        clk,
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic [7:0]       adr,
	output logic [3:0]       sel,
	output logic [31:0]      dat,
	input  wire logic [31:0] rdat,
	input  wire logic        ack
);
	// idle bus at time zero
	initial begin
		{cyc, stb, we} = 3'h0;
		adr = 8'h00;
		sel = 4'hF;
		dat = 32'h0;
	end

	// one request held until ack; no timeout of its own
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		dat <= ~d; // released data no longer shows the last word
	endtask
endmodule
`default_nettype wire

// ==== verification/ser_status_event_chk.sv ====
/*
 * Port-level assertions for the status and event block.
 * Assumes a bind onto ser_status_event and a single clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module ser_status_event_chk (
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        ce,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        newMsg,
	input wire logic        srq,
	input wire logic        irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// bus answer timing: one edge after taking, one cycle long
	chk_ack_one_cycle:
		assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o) else $error("ack late");
	chk_ack_single:
		assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	chk_ack_cause:
		assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i && ce))
		else $error("ack without request");
	// read data only moves when a read is taken
	chk_dat_hold:
		assert property (!$stable(wb_dat_o) |-> $past(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o))
		else $error("read data moved");
	// summary bit only drops through software or a new message
	chk_srq_clear:
		assert property ($fell(srq) |-> $past(wb_cyc_i && wb_stb_i || newMsg))
		else $error("srq dropped alone");
	chk_irq_clear:
		assert property ($fell(irq) |-> $past(wb_cyc_i && wb_stb_i)) else $error("irq dropped alone");
	chk_reset_quiet:
		assert property ($rose(arst_n) |-> !srq && !irq && !wb_ack_o) else $error("busy after reset");
	// enable low freezes every register, so outputs hold
	chk_ce_freeze:
		assert property (!ce |=> $stable(srq) && $stable(irq) && $stable(wb_ack_o))
		else $error("moved while frozen");
endmodule
`default_nettype wire

// ==== verification/ser_status_event_tb_top.sv ====
/*
 * Self-checking bench for the status and event block.
 * Assumes the host model for register access and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
module ser_status_event_tb_top;
	logic               clk;
	logic               arst_n;
	logic               ce;
	logic               cyc;
	logic               stb;
	logic               we;
	logic [7:0]         adr;
	logic [3:0]         sel;
	logic [31:0]        wdat;
	logic [31:0]        rdat;
	logic               ack;
	ser_pkg::ser_event_s evIn;
	ser_pkg::ser_resp_s  respIn;
	logic               newMsg;
	logic               opcQuery;
	logic               opBusy;
	logic               srq;
	logic               irq;
	int                 nFail;
	int                 testsRun;
	logic signed [15:0] codes [10] = '{16'sd100, 16'sd168, 16'sd200, 16'sd258, 16'sd300,
		16'sd310, 16'sd361, 16'sd401, 16'sd402, 16'sd500};
	int                 bits [10] = '{5, 5, 4, 4, 3, 3, 3, 7, 0, 3};

	ser_status_event #(.EVQ_DEPTH(2)) ser_status_event_i (.clk(clk), .arst_n(arst_n), .ce(ce),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .evIn(evIn), .respIn(respIn),
		.newMsg(newMsg), .opcQuery(opcQuery), .opBusy(opBusy), .srq(srq), .irq(irq));
	ser_host_model ser_host_model_i (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
		.sel(sel), .dat(wdat), .rdat(rdat), .ack(ack));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic testDone();
		if (nFail == 0 && testsRun > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// whole run is a few hundred cycles; this is far beyond it
	initial begin
		#200000;
		nFail++;
		testDone();
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		testsRun++;
		if (got !== exp) begin
			nFail++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ser_host_model_i.xfer(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		ser_host_model_i.xfer(1'b0, a, 32'h0, q);
		chk($sformatf("reg_%h", a), exp, q);
	endtask

	task automatic ev(input logic signed [15:0] c);
		@(posedge clk);
		evIn <= '{1'b1, c};
		@(posedge clk);
		evIn.valid <= 1'b0;
	endtask

	// main sequence
	initial begin
		arst_n = 1'b0;
		ce = 1'b1;
		evIn = '0;
		respIn = '0;
		{newMsg, opcQuery, opBusy} = 3'h0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		// every documented code except the overflow and query codes lands on its bit, queues, and pops
		for (int i = 0; i < 10; i++) begin
			ev(codes[i]);
			rdc(ser_pkg::ADDR_ESR, 32'h1 << bits[i]);
			wr(ser_pkg::ADDR_ESR, 32'hFF);
			rdc(ser_pkg::ADDR_EVQ_POP, 32'(codes[i]));
		end
		rdc(8'h40, 32'h0);
		wr(ser_pkg::ADDR_ESE, 32'h20);
		wr(ser_pkg::ADDR_SRE, 32'h20);
		wr(ser_pkg::ADDR_INT_MASK, 32'h1);
		rdc(ser_pkg::ADDR_ESE, 32'h20);
		rdc(ser_pkg::ADDR_SRE, 32'h20);
		rdc(ser_pkg::ADDR_INT_MASK, 32'h1);
		ev(16'sd150);
		rdc(ser_pkg::ADDR_STB, 32'h64);
		chk("srq", 1'b1, srq);
		chk("irq", 1'b1, irq);
		rdc(ser_pkg::ADDR_INT_STAT, 32'h9);
		wr(ser_pkg::ADDR_INT_MASK, 32'h0);
		chk("irq", 1'b0, irq);
		wr(ser_pkg::ADDR_INT_STAT, 32'hF);
		rdc(ser_pkg::ADDR_INT_STAT, 32'h0);
		wr(ser_pkg::ADDR_INT_MASK, 32'h1);
		chk("irq", 1'b0, irq);
		wr(ser_pkg::ADDR_ESR, 32'h20);
		rdc(ser_pkg::ADDR_STB, 32'h04);
		chk("srq", 1'b0, srq);
		rdc(ser_pkg::ADDR_EVQ_POP, 32'd150);
		rdc(ser_pkg::ADDR_STB, 32'h00);
		// depth two: third entry overwrites the newest with the overflow code
		ev(16'sd100);
		ev(16'sd200);
		ev(16'sd300);
		rdc(ser_pkg::ADDR_EVQ_CNT, 32'd2);
		rdc(ser_pkg::ADDR_EVQ_POP, 32'd100);
		rdc(ser_pkg::ADDR_EVQ_POP, 32'(ser_pkg::CODE_OVERFLOW));
		rdc(ser_pkg::ADDR_EVQ_CNT, 32'd0);
		rdc(ser_pkg::ADDR_ESR, 32'h38);
		wr(ser_pkg::ADDR_ESR, 32'hFF);
		// an event while the enable is low must leave no trace
		ce <= 1'b0;
		ev(16'sd100);
		ce <= 1'b1;
		rdc(ser_pkg::ADDR_EVQ_CNT, 32'd0);
		rdc(ser_pkg::ADDR_ESR, 32'h0);
		// completion query waits out the busy operation
		@(posedge clk);
		opBusy <= 1'b1;
		opcQuery <= 1'b1;
		@(posedge clk);
		opcQuery <= 1'b0;
		rdc(ser_pkg::ADDR_STB, 32'h00);
		opBusy <= 1'b0; // no new message while busy
		repeat (2) @(posedge clk);
		rdc(ser_pkg::ADDR_STB, 32'h10);
		rdc(ser_pkg::ADDR_OUTQ, ser_pkg::OPC_REPLY);
		// unread answer is dropped by the next message
		@(posedge clk);
		respIn <= '{1'b1, 32'h1234_5678};
		@(posedge clk);
		respIn.valid <= 1'b0;
		rdc(ser_pkg::ADDR_STB, 32'h10);
		newMsg <= 1'b1;
		@(posedge clk);
		newMsg <= 1'b0;
		repeat (2) @(posedge clk);
		rdc(ser_pkg::ADDR_STB, 32'h04);
		rdc(ser_pkg::ADDR_ESR, 32'h04);
		rdc(ser_pkg::ADDR_EVQ_POP, 32'(ser_pkg::CODE_QUERY));
		rdc(ser_pkg::ADDR_OUTQ, 32'h0);
		// an answer read before the next message comes back intact
		@(posedge clk);
		respIn <= '{1'b1, 32'hA5C3_0F01};
		@(posedge clk);
		respIn.valid <= 1'b0;
		rdc(ser_pkg::ADDR_OUTQ, 32'hA5C3_0F01);
		testDone();
	end
endmodule

bind ser_status_event ser_status_event_chk ser_status_event_chk_i (.clk(clk), .arst_n(arst_n),
	.ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .newMsg(newMsg), .srq(srq), .irq(irq));
`default_nettype wire
